//--- ddp_pkg.sv
// constants and types for the ddr3 device-side pin interface
package ddp_pkg;
  // command codes in {row strobe, column strobe, write enable} order
  typedef enum logic [2:0] {
    DDP_MRS, DDP_REF, DDP_PRE, DDP_ACT, DDP_WR, DDP_RD, DDP_ZQ, DDP_NOP
  } ddp_cmd_e;
  // power states
  typedef enum logic [1:0] {DDP_PS_ON, DDP_PS_PPD, DDP_PS_APD, DDP_PS_SR} ddp_pwr_e;
  // mode register indices
  localparam logic [1:0] DDP_MR0 = 2'h0;
  localparam logic [1:0] DDP_MR1 = 2'h1;
  localparam logic [1:0] DDP_MR2 = 2'h2;
  // address field positions
  localparam int DDP_A_AP = 10;    // auto precharge / precharge all
  localparam int DDP_A_BC = 12;    // burst chop on the fly
  // mr0 fields
  localparam int DDP_MR0_BL_LO = 0;
  localparam int DDP_MR0_BT = 3;
  localparam int DDP_MR0_CL_LO = 4;
  localparam logic [1:0] DDP_BL_FIX8 = 2'h0;
  localparam logic [1:0] DDP_BL_OTF = 2'h1;
  localparam logic [1:0] DDP_BL_FIX4 = 2'h2;
  localparam logic [4:0] DDP_CL_BASE = 5'h0_004;  // cl = code + 4, 4..11
  // mr1 fields
  localparam int DDP_MR1_AL_LO = 3;
  localparam int DDP_MR1_TDQS = 11;
  localparam int DDP_MR1_RTT0 = 2;
  localparam int DDP_MR1_RTT1 = 6;
  localparam int DDP_MR1_RTT2 = 9;
  // mr2 fields
  localparam int DDP_MR2_CWL_LO = 3;
  localparam int DDP_MR2_RTTWR_LO = 9;
  localparam logic [4:0] DDP_CWL_BASE = 5'h0_005;
  // burst lengths
  localparam logic [3:0] DDP_LEN4 = 4'h4;
  localparam logic [3:0] DDP_LEN8 = 4'h8;
  // reset values
  localparam logic [14:0] DDP_MR_RST = 15'h0000;
endpackage

//--- ddp_dram_pins.sv
// ddr3 sdram device-side command, data, strobe, cke, odt and reset pin logic
// Notes on behaviour
// RULE_01: commands and addresses taken on clock rising edge
// RULE_02: cke high enables clocks, buffers and drivers
// RULE_03: cke low: idle banks power-down/refresh, else active
// RULE_04: cke sampled synchronously; self-refresh exit asynchronous
// RULE_05: controller keeps cke high during accesses
// RULE_06: power-down keeps ck/odt/cke; self-refresh only cke
// RULE_07: chip select high masks every command
// RULE_08: command from row, column, write strobes
// RULE_09: mask high at a beat blocks that byte
// RULE_10: byte-wide parts: mr1 bit selects mask/tdqs
// RULE_11: bank bits pick bank or mode register
// RULE_12: address carries row, column or opcode
// RULE_13: address bit 12: high full, low chopped
// RULE_14: read strobe edge-aligned; write strobe centered
// RULE_15: strobes are differential pairs only
// RULE_16: registered odt enables termination on data lines
// RULE_17: odt ignored when all termination disabled
// RULE_18: reset pin active low, asynchronous
// RULE_19: read latency programmable six to eleven; cl here is code + 4, 4..11
// RULE_20: additive latency zero, cl-1 or cl-2
// RULE_21: burst length 4 or 8, order selectable
// RULE_22: eight independently addressed banks
// RULE_23: chop bit honoured only when on-the-fly enabled
// RULE_24: controller writes all mode registers first
// RULE_25: command truth table from the four strobes
`timescale 1ns/1ps
module ddp_dram_pins #(
  parameter int BANKS     = 8,   // internal banks
  parameter int COL_BITS  = 3,   // column address bits held per bank in the array
  parameter int BYTES     = 2,   // byte lanes
  parameter bit BYTE_WIDE = 1'b0 // one for byte-wide parts (mask/tdqs pin)
) (
  // user-side clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_srst,
  // link clock and reset pin
  input  wire logic                   i_ck,
  input  wire logic                   i_rst_n,
  // command and address pins
  input  wire logic                   i_cke,
  input  wire logic                   i_cs_n,
  input  wire logic                   i_ras_n,
  input  wire logic                   i_cas_n,
  input  wire logic                   i_we_n,
  input  wire logic [2:0]             i_ba,
  input  wire logic [14:0]            i_addr,
  input  wire logic                   i_odt,
  // data pins
  input  wire logic [BYTES-1:0]       i_dm,
  input  wire logic [BYTES*8-1:0]     i_dq,
  output logic      [BYTES*8-1:0]     o_dq,
  output logic                        o_dq_oe,
  input  wire logic [BYTES-1:0]       i_dqs,
  input  wire logic [BYTES-1:0]       i_dqs_n,
  output logic      [BYTES-1:0]       o_dqs,
  output logic      [BYTES-1:0]       o_dqs_n,
  output logic                        o_dqs_oe,
  // termination controls
  output logic                        o_term_en,
  output logic                        o_term_xstrobe,
  // user-side status
  output logic                        o_cmd_valid,
  output ddp_pkg::ddp_cmd_e           o_cmd_code,
  output logic      [2:0]             o_cmd_bank,
  output logic                        o_power_down,
  output logic                        o_self_refresh
);
  import ddp_pkg::*;

  localparam int DQ_W = BYTES * 8;
  localparam int IDX_W = 3 + COL_BITS;

  // burst column for beat b: wraps within a 4 or 8 group
  function automatic logic [2:0] burst_col(input logic [2:0] start, input logic [2:0] b,
                                           input logic ilv, input logic len4);
    logic [2:0] c;
    c = ilv ? (start ^ b) : 3'(start + b);
    if (len4) begin
      c = {start[2], c[1:0]};
    end
    return c;
  endfunction

  // link-domain reset: asserts at once, releases on a ck edge
  logic rst_meta_n;  // first stage, read only by the next flop
  logic rst_ok;      // released reset
  always_ff @(posedge i_ck or negedge i_rst_n) begin
    if (!i_rst_n) begin // RULE_18
      rst_meta_n <= 1'b0;
      rst_ok     <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_ok     <= rst_meta_n;
    end
  end

  // self-refresh wake: cke rise toggles with no ck needed
  logic srx_tgl;   // toggles on every cke rise
  always_ff @(posedge i_cke or negedge i_rst_n) begin
    if (!i_rst_n) begin
      srx_tgl <= 1'b0;
    end else begin
      srx_tgl <= ~srx_tgl; // RULE_04
    end
  end

  // bring the wake toggle onto ck
  logic srx_m, srx_s, srx_seen;
  always_ff @(posedge i_ck) begin
    if (!rst_ok) begin
      srx_m    <= 1'b0;
      srx_s    <= 1'b0;
      srx_seen <= 1'b0;
    end else begin
      srx_m    <= srx_tgl;
      srx_s    <= srx_m;
      srx_seen <= srx_s;
    end
  end
  wire srx_evt = srx_s ^ srx_seen;  // one ck pulse per wake

  // mode registers, bank state and power state
  logic [14:0]       mr [4];        // contents undefined to the controller until written
  logic [BANKS-1:0]  bank_open;     // one bit per bank with an open row
  logic [14:0]       open_row [BANKS];
  ddp_pwr_e          pwr;
  logic              cke_q;         // cke seen at the previous edge
  logic              cke_seen;      // cke registered high since reset

  // command decode
  ddp_cmd_e cmd;
  assign cmd = ddp_cmd_e'({i_ras_n, i_cas_n, i_we_n}); // RULE_08 RULE_25
  // inputs count only with cke high on this and the last edge
  wire run     = rst_ok && (pwr == DDP_PS_ON) && cke_q && i_cke; // RULE_02 RULE_06
  wire cmd_on  = run && !i_cs_n; // RULE_07
  wire all_idle = (bank_open == '0);

  // mode register fields
  wire [1:0] bl_mode  = mr[DDP_MR0][DDP_MR0_BL_LO +: 2];
  wire       ilv      = mr[DDP_MR0][DDP_MR0_BT]; // RULE_21
  wire [4:0] cl       = 5'(mr[DDP_MR0][DDP_MR0_CL_LO +: 3]) + DDP_CL_BASE; // RULE_19
  wire [1:0] al_code  = mr[DDP_MR1][DDP_MR1_AL_LO +: 2];
  wire [4:0] al       = (al_code == 2'h1) ? 5'(cl - 5'h0_001) :
                        (al_code == 2'h2) ? 5'(cl - 5'h0_002) : 5'h0_000; // RULE_20
  wire [4:0] cwl      = 5'(mr[DDP_MR2][DDP_MR2_CWL_LO +: 3]) + DDP_CWL_BASE;
  wire [4:0] rl       = 5'(al + cl);
  wire [4:0] wl       = 5'(al + cwl);
  wire       tdqs_en  = mr[DDP_MR1][DDP_MR1_TDQS];
  wire       rtt_nom  = mr[DDP_MR1][DDP_MR1_RTT0] | mr[DDP_MR1][DDP_MR1_RTT1] | mr[DDP_MR1][DDP_MR1_RTT2];
  wire       rtt_wr   = |mr[DDP_MR2][DDP_MR2_RTTWR_LO +: 2];
  wire       dm_mask  = !(BYTE_WIDE && tdqs_en); // RULE_10

  // chop: fixed bc4, or on the fly from address bit 12 when enabled
  wire chop = (bl_mode == DDP_BL_FIX4) ||
              ((bl_mode == DDP_BL_OTF) && !i_addr[DDP_A_BC]); // RULE_13 RULE_23

  // power state machine, cke sampled on ck for entry and pd exit
  always_ff @(posedge i_ck) begin
    if (!rst_ok) begin
      pwr      <= DDP_PS_ON;
      cke_q    <= 1'b0;
      cke_seen <= 1'b0;
    end else begin
      cke_q <= i_cke;
      if (i_cke) begin
        cke_seen <= 1'b1;
      end
      unique case (pwr)
        DDP_PS_ON: begin
          // falling cke chooses the low-power mode
          if (cke_q && !i_cke) begin
            if (!i_cs_n && cmd == DDP_REF && all_idle) begin
              pwr <= DDP_PS_SR; // RULE_03 RULE_04
            end else if (all_idle) begin
              pwr <= DDP_PS_PPD; // RULE_03
            end else begin
              pwr <= DDP_PS_APD; // RULE_03
            end
          end
        end
        DDP_PS_PPD, DDP_PS_APD: begin
          // synchronous exit on cke high
          if (i_cke) begin
            pwr <= DDP_PS_ON; // RULE_04
          end
        end
        DDP_PS_SR: begin
          // exit comes from the asynchronous wake detector
          if (srx_evt) begin
            pwr <= DDP_PS_ON; // RULE_04
          end
        end
      endcase
    end
  end

  // mode register writes: bank bits pick the register
  always_ff @(posedge i_ck) begin // RULE_01
    if (!rst_ok) begin
      for (int i = 0; i < 4; i++) begin
        mr[i] <= DDP_MR_RST;
      end
    end else if (cmd_on && cmd == DDP_MRS && !i_ba[2]) begin
      mr[i_ba[1:0]] <= i_addr; // RULE_11 RULE_12
    end
  end

  // bank open/closed tracking with row capture
  always_ff @(posedge i_ck) begin
    if (!rst_ok) begin
      bank_open <= '0;
    end else if (cmd_on) begin
      unique case (cmd)
        DDP_ACT: begin
          bank_open[i_ba] <= 1'b1; // RULE_11 RULE_22
        end
        DDP_PRE: begin
          // address bit 10 closes every bank
          if (i_addr[DDP_A_AP]) begin
            bank_open <= '0;
          end else begin
            bank_open[i_ba] <= 1'b0;
          end
        end
        DDP_RD, DDP_WR: begin
          // auto precharge closes the bank at once; no trp model
          if (i_addr[DDP_A_AP]) begin
            bank_open[i_ba] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // row address held per bank
  always_ff @(posedge i_ck) begin
    if (cmd_on && cmd == DDP_ACT) begin
      open_row[i_ba] <= i_addr; // RULE_12
    end
  end

  // burst engine: one read or write at a time
  logic       lat_busy;    // waiting out the latency
  logic [4:0] lat_cnt;
  logic       b_act;       // beats in progress
  logic       b_wr;        // direction of the pending burst
  logic       b_len4;
  logic [2:0] b_bank;
  logic [2:0] b_col;
  logic [3:0] beat;
  wire  [3:0] b_len = b_len4 ? DDP_LEN4 : DDP_LEN8;
  wire  idle_eng = !lat_busy && !b_act;
  // a new read/write while a burst is pending is dropped
  wire  go_cmd = cmd_on && idle_eng && (cmd == DDP_RD || cmd == DDP_WR);
  wire  lat_done = lat_busy && (lat_cnt == 5'h0_001);

  always_ff @(posedge i_ck) begin
    if (!rst_ok) begin
      lat_busy <= 1'b0;
      lat_cnt  <= 5'h0_000;
      b_wr     <= 1'b0;
      b_len4   <= 1'b0;
      b_bank   <= 3'h0;
      b_col    <= 3'h0;
    end else if (go_cmd) begin
      lat_busy <= 1'b1;
      lat_cnt  <= (cmd == DDP_RD) ? 5'(rl - 5'h0_001) : wl; // RULE_19 RULE_20
      b_wr     <= (cmd == DDP_WR);
      b_len4   <= chop; // RULE_13 RULE_21
      b_bank   <= i_ba; // RULE_11
      b_col    <= i_addr[2:0]; // RULE_12
    end else if (lat_busy) begin
      lat_cnt <= 5'(lat_cnt - 5'h0_001);
      if (lat_done) begin
        lat_busy <= 1'b0;
      end
    end
  end

  // beat counter and active flag
  always_ff @(posedge i_ck) begin
    if (!rst_ok) begin
      b_act <= 1'b0;
      beat  <= 4'h0;
    end else if (lat_done) begin
      b_act <= 1'b1;
      beat  <= b_wr ? 4'h0 : 4'h1;
    end else if (b_act) begin
      if ((b_wr && beat == 4'(b_len - 4'h1)) || (!b_wr && beat == b_len)) begin
        b_act <= 1'b0;
      end else begin
        beat <= 4'(beat + 4'h1);
      end
    end
  end

  // array index of the current beat
  wire [2:0] cur_col = burst_col(b_col, beat[2:0], ilv, b_len4); // RULE_21
  wire [2:0] first_col = burst_col(b_col, 3'h0, ilv, b_len4);
  wire [IDX_W-1:0] cur_idx = {b_bank, COL_BITS'(cur_col)};
  wire [IDX_W-1:0] first_idx = {b_bank, COL_BITS'(first_col)};

  // storage: flip-flops, bank and column index
  logic [DQ_W-1:0] mem [2**IDX_W];
  wire  wr_beat = b_act && b_wr && i_cke; // RULE_05

  // masked write: each byte written unless its mask was high while the pin acts as a mask (not tdqs)
  always_ff @(posedge i_ck) begin
    if (wr_beat) begin
      for (int b = 0; b < BYTES; b++) begin
        if (!(dm_mask && i_dm[b])) begin
          mem[cur_idx][b*8 +: 8] <= i_dq[b*8 +: 8]; // RULE_09
        end
      end
    end
  end

  // read data out, one word per ck edge
  wire rd_drive = (lat_done && !b_wr) || (b_act && !b_wr && beat != b_len);
  always_ff @(posedge i_ck) begin
    if (!rst_ok) begin
      o_dq    <= '0;
      o_dq_oe <= 1'b0;
    end else begin
      // drivers off whenever cke is low
      o_dq_oe <= rd_drive && i_cke; // RULE_02
      if (lat_done) begin
        o_dq <= mem[first_idx];
      end else if (rd_drive) begin
        o_dq <= mem[cur_idx];
      end
    end
  end

  // read strobe pair: flips with each word so edges line up with data
  always_ff @(posedge i_ck) begin
    if (!rst_ok) begin
      o_dqs    <= '0;
      o_dqs_n  <= '1;
      o_dqs_oe <= 1'b0;
    end else begin
      o_dqs_oe <= rd_drive && i_cke; // RULE_14 RULE_15
      if (rd_drive) begin
        o_dqs   <= ~o_dqs; // RULE_14
        o_dqs_n <= o_dqs;  // RULE_15
      end else begin
        o_dqs   <= '0;
        o_dqs_n <= '1;
      end
    end
  end

  // on-die termination: off until cke seen high, and in self-refresh
  wire odt_ok = cke_seen && (pwr != DDP_PS_SR) && (rtt_nom || rtt_wr); // RULE_17 RULE_06
  always_ff @(posedge i_ck) begin
    if (!rst_ok) begin
      o_term_en      <= 1'b0;
      o_term_xstrobe <= 1'b0;
    end else begin
      o_term_en      <= odt_ok && i_odt; // RULE_16
      o_term_xstrobe <= odt_ok && i_odt && BYTE_WIDE && tdqs_en; // RULE_16
    end
  end

  // command event to the user side: toggle plus held code
  logic       cmd_tgl;
  ddp_cmd_e   cmd_hold;
  logic [2:0] bank_hold;
  logic       pd_flag, sr_flag;
  always_ff @(posedge i_ck) begin
    if (!rst_ok) begin
      cmd_tgl   <= 1'b0;
      cmd_hold  <= DDP_NOP;
      bank_hold <= 3'h0;
      pd_flag   <= 1'b0;
      sr_flag   <= 1'b0;
    end else begin
      pd_flag <= (pwr == DDP_PS_PPD) || (pwr == DDP_PS_APD);
      sr_flag <= (pwr == DDP_PS_SR);
      // nop and deselect are not reported
      if (cmd_on && cmd != DDP_NOP) begin
        cmd_tgl   <= ~cmd_tgl;
        cmd_hold  <= cmd;
        bank_hold <= i_ba;
      end
    end
  end

  // user-domain synchronisers; held words are stable when the toggle lands
  logic tgl_m, tgl_s, tgl_d;
  logic pd_m, pd_s, sr_m, sr_s;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tgl_m <= 1'b0;
      tgl_s <= 1'b0;
      tgl_d <= 1'b0;
      pd_m  <= 1'b0;
      pd_s  <= 1'b0;
      sr_m  <= 1'b0;
      sr_s  <= 1'b0;
    end else begin
      tgl_m <= cmd_tgl;
      tgl_s <= tgl_m;
      tgl_d <= tgl_s;
      pd_m  <= pd_flag;
      pd_s  <= pd_m;
      sr_m  <= sr_flag;
      sr_s  <= sr_m;
    end
  end

  // user-side outputs
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_cmd_valid    <= 1'b0;
      o_cmd_code     <= DDP_NOP;
      o_cmd_bank     <= 3'h0;
      o_power_down   <= 1'b0;
      o_self_refresh <= 1'b0;
    end else begin
      o_cmd_valid    <= tgl_s ^ tgl_d;
      o_power_down   <= pd_s;
      o_self_refresh <= sr_s;
      if (tgl_s ^ tgl_d) begin
        o_cmd_code <= cmd_hold;
        o_cmd_bank <= bank_hold;
      end
    end
  end

endmodule

//--- ddp_host_model.sv
// host controller model driving the ddr3 link pins
`timescale 1ns/1ps
module ddp_host_model (
  // link clock and read return
  input  wire logic        i_ck,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_dq_oe,
  // pins toward the device
  output logic             o_rst_n,
  output logic             o_cke,
  output logic             o_cs_n,
  output logic [2:0]       o_cmd,
  output logic [2:0]       o_ba,
  output logic [14:0]      o_addr,
  output logic             o_odt,
  output logic [1:0]       o_dm,
  output logic [15:0]      o_dq,
  output logic [1:0]       o_dqs,
  output logic [1:0]       o_dqs_n
);
  import ddp_pkg::*;
  // everything except the write strobe changes on the falling ck edge
  initial begin
    o_rst_n = 1'b0;
    o_cke = 1'b0;
    o_cs_n = 1'b1;
    o_cmd = 3'h7;
    o_ba = 3'h0;
    o_addr = 15'h0000;
    o_odt = 1'b0;
    o_dm = 2'h0;
    o_dq = 16'h0000;
    o_dqs = 2'h0;
    o_dqs_n = 2'h3;
  end
  // reset pulse, then cke raised with deselect on the bus
  task automatic init();
    o_rst_n <= 1'b0;
    o_cke <= 1'b0;
    repeat (3) @(negedge i_ck);
    o_rst_n <= 1'b1;
    repeat (3) @(negedge i_ck);
    o_cke <= 1'b1;
    repeat (6) @(negedge i_ck);
  endtask
  // async reset in mid-run
  task automatic hit_reset();
    @(negedge i_ck);
    o_rst_n <= 1'b0;
    #1;
  endtask
  task automatic pins(input logic ke, input logic t);
    @(negedge i_ck);
    o_cke <= ke;
    o_odt <= t;
  endtask
  // one command, then released lines flip so stale values never match
  task automatic cmd(input logic [2:0] c, input logic [2:0] ba, input logic [14:0] a, input logic cs, input logic ke);
    @(negedge i_ck);
    o_cs_n <= cs;
    o_cmd <= c;
    o_ba <= ba;
    o_addr <= a;
    o_cke <= ke;
    @(negedge i_ck);
    o_cs_n <= 1'b1;
    o_cmd <= ~c;
    o_ba <= ~ba;
    o_addr <= ~a;
  endtask
  // write burst, beats taken at edges 6..13 (cwl 5, al 0); cke stays high
  task automatic wr(input logic [2:0] ba, input logic [14:0] a, input logic [15:0] d [8], input logic [1:0] m [8]);
    cmd(DDP_WR, ba, a, 1'b0, 1'b1);
    repeat (5) @(negedge i_ck);
    for (int i = 0; i < 8; i++) begin
      o_dq <= d[i];
      o_dm <= m[i];
      @(posedge i_ck);
      o_dqs <= ~o_dqs;
      o_dqs_n <= o_dqs;
      @(negedge i_ck);
    end
    o_dq <= ~o_dq;
    o_dm <= 2'h0;
  endtask
  // read burst, nine samples just after edges 5..13
  task automatic rd(input logic [2:0] ba, input logic [14:0] a, output logic [15:0] q [9], output logic [8:0] oe);
    cmd(DDP_RD, ba, a, 1'b0, 1'b1);
    repeat (4) @(posedge i_ck);
    for (int i = 0; i < 9; i++) begin
      @(posedge i_ck);
      #1;
      q[i] = i_dq;
      oe[i] = i_dq_oe;
    end
  endtask
endmodule

//--- ddp_dram_pins_sva.sv
// concurrent checks on the ddr3 device pin logic
`timescale 1ns/1ps
module ddp_dram_pins_chk #(
  parameter int BYTES     = 2,
  parameter bit BYTE_WIDE = 1'b0
) (
  // clocks and resets
  input wire logic              i_clock,
  input wire logic              i_srst,
  input wire logic              i_ck,
  input wire logic              i_rst_n,
  // watched pins
  input wire logic              i_cke,
  input wire logic              i_odt,
  input wire logic              o_dq_oe,
  input wire logic [BYTES-1:0]  o_dqs,
  input wire logic [BYTES-1:0]  o_dqs_n,
  input wire logic              o_dqs_oe,
  input wire logic              o_term_en,
  input wire logic              o_term_xstrobe,
  // user status
  input wire logic              o_cmd_valid,
  input wire ddp_pkg::ddp_cmd_e o_cmd_code,
  input wire logic              o_self_refresh
);
  import ddp_pkg::*;
  // start of a read burst
  sequence s_rd_start;
    $rose(o_dq_oe);
  endsequence
  a_dqs_pair: assert property (@(posedge i_ck) disable iff (!i_rst_n) o_dqs_n == ~o_dqs)
    else $error("read strobe halves not complementary");
  a_strobe_data: assert property (@(posedge i_ck) disable iff (!i_rst_n) o_dqs_oe == o_dq_oe)
    else $error("read strobe enable apart from data enable");
  a_dqs_toggle: assert property (@(posedge i_ck) disable iff (!i_rst_n)
    o_dq_oe && $past(o_dq_oe) |-> o_dqs != $past(o_dqs)) else $error("read strobe missed a word");
  a_burst_min: assert property (@(posedge i_ck) disable iff (!i_rst_n) s_rd_start |-> o_dq_oe[*4])
    else $error("read burst shorter than four");
  a_burst_max: assert property (@(posedge i_ck) disable iff (!i_rst_n) s_rd_start |-> ##[4:8] !o_dq_oe)
    else $error("read burst longer than eight");
  a_cke_quiet: assert property (@(posedge i_ck) disable iff (!i_rst_n)
    !i_cke && $past(!i_cke) |-> !o_dq_oe) else $error("driving data with cke low");
  a_odt_cause: assert property (@(posedge i_ck) disable iff (!i_rst_n)
    $rose(o_term_en) |-> $past(i_odt) || $past(i_odt, 2)) else $error("termination without odt");
  a_xstrobe_off: assert property (@(posedge i_ck) disable iff (!i_rst_n) !BYTE_WIDE |-> !o_term_xstrobe)
    else $error("extra strobe termination on wide part");
  a_cmd_pulse: assert property (@(posedge i_clock) disable iff (i_srst) o_cmd_valid |=> !o_cmd_valid)
    else $error("command report longer than one cycle");
  a_cmd_real: assert property (@(posedge i_clock) disable iff (i_srst) o_cmd_valid |-> o_cmd_code != DDP_NOP)
    else $error("no-op reported as command");
  a_sr_quiet: assert property (@(posedge i_clock) disable iff (i_srst) o_self_refresh |-> !o_dq_oe)
    else $error("driving data in self-refresh");
endmodule
bind ddp_dram_pins ddp_dram_pins_chk #(.BYTES(BYTES), .BYTE_WIDE(BYTE_WIDE)) u_chk (
  .i_clock(i_clock), .i_srst(i_srst), .i_ck(i_ck), .i_rst_n(i_rst_n), .i_cke(i_cke), .i_odt(i_odt),
  .o_dq_oe(o_dq_oe), .o_dqs(o_dqs), .o_dqs_n(o_dqs_n), .o_dqs_oe(o_dqs_oe), .o_term_en(o_term_en),
  .o_term_xstrobe(o_term_xstrobe), .o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code),
  .o_self_refresh(o_self_refresh)
);

//--- testbench.sv
// self-checking bench for the ddr3 device pin logic
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module testbench;
  import ddp_pkg::*;
  logic              clk, srst, ck, rst_n, cke, cs_n, odt, dq_oe, term_en, term_x, cmd_valid, pd, sr;
  logic [2:0]        cmd, ba, cmd_bank, last_bank;
  logic [14:0]       addr;
  logic [1:0]        dm, dqs_w, dqs_nw;
  logic [15:0]       dq_w, dq_r, dq_bus;
  ddp_cmd_e          cmd_code, last_code;
  int                n_fail, n_tests, n_cmd, cycles;
  // shared data line: device wins while it drives
  assign dq_bus = dq_oe ? dq_r : dq_w;
  ddp_dram_pins dut (
    .i_clock(clk), .i_srst(srst), .i_ck(ck), .i_rst_n(rst_n), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba), .i_addr(addr), .i_odt(odt),
    .i_dm(dm), .i_dq(dq_bus), .o_dq(dq_r), .o_dq_oe(dq_oe), .i_dqs(dqs_w), .i_dqs_n(dqs_nw),
    .o_dqs(), .o_dqs_n(), .o_dqs_oe(), .o_term_en(term_en), .o_term_xstrobe(term_x),
    .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code), .o_cmd_bank(cmd_bank),
    .o_power_down(pd), .o_self_refresh(sr));
  ddp_host_model host (
    .i_ck(ck), .i_dq(dq_bus), .i_dq_oe(dq_oe), .o_rst_n(rst_n), .o_cke(cke), .o_cs_n(cs_n),
    .o_cmd(cmd), .o_ba(ba), .o_addr(addr), .o_odt(odt), .o_dm(dm), .o_dq(dq_w), .o_dqs(dqs_w),
    .o_dqs_n(dqs_nw));
  // clocks: link clock unrelated in phase
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    ck = 1'b0;
    #1.3;
    forever #6 ck = ~ck;
  end
  // collect command reports; timeout guard
  always @(posedge clk) begin
    cycles++;
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_code = cmd_code;
      last_bank = cmd_bank;
    end
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one command, then its report (or none when deselected)
  task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [14:0] a, input logic cs);
    int n0;
    n0 = n_cmd;
    host.cmd(c, b, a, cs, 1'b1);
    repeat (8) @(posedge clk);
    `CHK(n_cmd - n0, cs ? 0 : 1)
    if (!cs) begin
      `CHK(last_code, ddp_cmd_e'(c))
      `CHK(last_bank, b)
    end
  endtask
  task automatic t_init();
    host.init();
    issue(DDP_MRS, 3'h2, 15'h0000, 1'b0);
    issue(DDP_MRS, 3'h3, 15'h0000, 1'b0);
    issue(DDP_MRS, 3'h1, 15'h0004, 1'b0);
    issue(DDP_MRS, 3'h0, 15'h0020, 1'b0);
    $display("init done");
  endtask
  task automatic t_cmds();
    for (int b = 0; b < 8; b++) begin
      issue(DDP_ACT, b[2:0], 15'h0100, 1'b0);
      issue(DDP_PRE, b[2:0], 15'h0000, 1'b0);
    end
    issue(DDP_REF, 3'h0, 15'h0000, 1'b0);
    issue(DDP_ZQ, 3'h0, 15'h0400, 1'b0);
    issue(DDP_ACT, 3'h5, 15'h0000, 1'b1);
    $display("command decode done");
  endtask
  // masked overwrite, then fixed and chopped reads
  task automatic t_data();
    logic [15:0] p [8];
    logic [15:0] d [8];
    logic [15:0] q [9];
    logic [1:0]  m [8];
    logic [1:0]  z [8];
    logic [8:0]  oe;
    for (int i = 0; i < 8; i++) begin
      p[i] = 16'h1100 + 16'(i);
      d[i] = 16'hA0B0 + 16'(i);
      z[i] = 2'h0;
      m[i] = (i == 2) ? 2'h2 : ((i == 5) ? 2'h1 : 2'h0);
    end
    issue(DDP_ACT, 3'h3, 15'h0040, 1'b0);
    host.wr(3'h3, 15'h1000, p, z);
    host.wr(3'h3, 15'h1000, d, m);
    host.rd(3'h3, 15'h0000, q, oe);
    `CHK(oe, 9'h0FF)
    for (int i = 0; i < 8; i++) begin
      `CHK(q[i][15:8], m[i][1] ? p[i][15:8] : d[i][15:8])
      `CHK(q[i][7:0], m[i][0] ? p[i][7:0] : d[i][7:0])
    end
    issue(DDP_MRS, 3'h0, 15'h0021, 1'b0);
    host.rd(3'h3, 15'h0000, q, oe);
    `CHK(oe, 9'h00F)
    `CHK(q[3], d[3])
    host.rd(3'h3, 15'h1000, q, oe);
    `CHK(oe, 9'h0FF)
    issue(DDP_MRS, 3'h0, 15'h0028, 1'b0);
    host.rd(3'h3, 15'h1001, q, oe);
    `CHK(q[1], d[0])
    issue(DDP_MRS, 3'h0, 15'h0020, 1'b0);
    issue(DDP_MRS, 3'h1, 15'h000C, 1'b0);
    host.rd(3'h3, 15'h0000, q, oe);
    `CHK(oe, 9'h1E0)
    `CHK(q[5], d[0])
    issue(DDP_MRS, 3'h1, 15'h0004, 1'b0);
    $display("data path done");
  endtask
  task automatic t_power();
    int n0;
    issue(DDP_PRE, 3'h0, 15'h0400, 1'b0);
    issue(DDP_ACT, 3'h1, 15'h0000, 1'b0);
    host.pins(1'b0, 1'b0);
    repeat (40) @(posedge clk);
    `CHK(pd, 1'b1)
    `CHK(sr, 1'b0)
    n0 = n_cmd;
    host.cmd(DDP_PRE, 3'h1, 15'h0000, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    `CHK(n_cmd - n0, 0)
    host.pins(1'b1, 1'b0);
    repeat (40) @(posedge clk);
    `CHK(pd, 1'b0)
    issue(DDP_PRE, 3'h1, 15'h0000, 1'b0);
    host.cmd(DDP_REF, 3'h0, 15'h0000, 1'b0, 1'b0);
    repeat (40) @(posedge clk);
    `CHK(sr, 1'b1)
    host.pins(1'b1, 1'b0);
    repeat (40) @(posedge clk);
    `CHK(sr, 1'b0)
    $display("power states done");
  endtask
  task automatic t_odt();
    host.pins(1'b1, 1'b1);
    repeat (4) @(negedge ck);
    `CHK(term_en, 1'b1)
    `CHK(term_x, 1'b0)
    host.pins(1'b1, 1'b0);
    repeat (4) @(negedge ck);
    `CHK(term_en, 1'b0)
    issue(DDP_MRS, 3'h1, 15'h0000, 1'b0);
    host.pins(1'b1, 1'b1);
    repeat (4) @(negedge ck);
    `CHK(term_en, 1'b0)
    issue(DDP_MRS, 3'h1, 15'h0004, 1'b0);
    repeat (4) @(negedge ck);
    `CHK(term_en, 1'b1)
    host.hit_reset();
    @(negedge ck);
    `CHK(term_en, 1'b0)
    `CHK(dq_oe, 1'b0)
    host.init();
    $display("termination and reset done");
  endtask
  initial begin
    srst = 1'b1;
    n_fail = 0;
    n_tests = 0;
    n_cmd = 0;
    cycles = 0;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    t_init();
    t_cmds();
    t_data();
    t_power();
    t_odt();
    end_of_test();
  end
endmodule
